// ### hdl/nvba_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses are four times the printed register index
// Notes: included by nvba_top only
`ifndef NVBA_REGS_SVH
`define NVBA_REGS_SVH
`define NVBA_IDX_DATA      8'h9a
`define NVBA_IDX_ADDR      8'h9b
`define NVBA_IDX_CTRL      8'h9c
`define NVBA_IDX_KEY       8'h9d
`define NVBA_IDX_FLAG      8'h0c
`define NVBA_IDX_RESET     8'h80
`define NVBA_BIT_FETCH     0
`define NVBA_BIT_GO        1
`define NVBA_BIT_PERMIT    2
`define NVBA_BIT_FAULT     3
`define NVBA_BIT_DONE      7
`define NVBA_RST_FAULT     1'b0
`define NVBA_RST_PERMIT    1'b0
`define NVBA_KEY_FIRST     8'h55
`define NVBA_KEY_SECOND    8'hAA
`define NVBA_KEY_GAP       3
`define NVBA_PROG_TIME_US  4
`define NVBA_CLK_MHZ       40
`define NVBA_PROG_CYCLES   (`NVBA_PROG_TIME_US * `NVBA_CLK_MHZ)
`endif

// ### hdl/nvba_pkg.sv
// Purpose: types shared by the byte access logic
// Assumes: nothing
// Notes: constants live in nvba_regs.svh
package nvba_pkg;
	typedef enum logic [1:0]
	{
		NVBA_IDLE  = 2'b00,
		NVBA_KEY1  = 2'b01,
		NVBA_KEY2  = 2'b11
	} nvba_key_e;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] data;
		logic       permit;
		logic       go;
		logic       fetch;
		logic       fault;
		logic       done;
	} nvba_regs_s;
	typedef logic [7:0] nvba_byte_t;
endpackage

// ### hdl/nvba_top.sv
// Purpose: byte read/write control for a 128 byte nonvolatile data array
// Assumes: AHB-Lite slave, single word transfers, one wait-free data phase
// Notes: array is modelled as a register array; write time is a parameter
//
// Overview of operation
// R01 - control bits seven to four read zero
// R02 - reset during a write sets fault flag
// R03 - permit bit gates writes, resets to zero
// R04 - go bit starts write, hardware clears it
// R05 - fetch bit starts read, hardware clears it
// R06 - read data ready next cycle
// R07 - data register holds read value
// R08 - software loads address before read
// R09 - software loads address and data first
// R10 - write needs 55h, AAh, then go
// R11 - wrong sequence cycle count blocks write
// R12 - software disables interrupts around sequence
// R13 - go blocked while permit is zero
// R14 - clearing permit leaves running write alone
// R15 - hardware never clears permit bit
// R16 - software keeps permit zero normally
// R17 - write end clears go, sets done
// R18 - done flag cleared only by software
// R19 - key port reads zero, stores nothing
// R20 - 128 bytes, low seven address bits
// R21 - byte write erases before programming
// R22 - address and data survive aborted write
// R23 - internal timer sets write duration
// R24 - reads held off during a write
`timescale 1ns/1ps
`include "nvba_regs.svh"
module nvba_top
	import nvba_pkg::*;
#(
	parameter int PROG_CYCLES = `NVBA_PROG_CYCLES,
	parameter int KEY_GAP     = `NVBA_KEY_GAP
)
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        EXT_PIN_RST,
	input  wire logic        WDOG_RST,
	input  wire logic        BROWNOUT_RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             PROG_DONE
);
	initial
	begin
		if (PROG_CYCLES < 1)
			$error("nvba_top: write time must be at least one cycle");
		if (KEY_GAP < 1)
			$error("nvba_top: key gap must be at least one cycle");
		if (KEY_GAP > 15)
			$error("nvba_top: key gap must fit the four bit counter");
	end

	logic        bus_ok;
	logic        wr_ph_r;
	logic        wr_ph_nxt;
	logic [7:0]  wr_idx_r;
	logic [7:0]  wr_idx_nxt;
	logic [31:0] rdata_nxt;
	logic        soft_rst;
	logic        abort_rst;
	nvba_regs_s  regs_r;
	nvba_regs_s  regs_nxt;
	nvba_key_e   key_r;
	nvba_key_e   key_nxt;
	logic [3:0]  gap_r;
	logic [3:0]  gap_nxt;
	logic [31:0] tmr_r;
	logic [31:0] tmr_nxt;
	logic [7:0]  prog_addr_r;
	logic [7:0]  prog_addr_nxt;
	logic [7:0]  prog_data_r;
	logic [7:0]  prog_data_nxt;
	nvba_byte_t  mem_r [0:127];
	logic        mem_we;
	logic        key_wr;
	logic        ctl_wr;
	logic        go_start;

	function automatic logic [7:0] idx_of(input logic [31:0] a);
		idx_of = a[9:2];
	endfunction

	function automatic logic [31:0] byte_word(input nvba_byte_t b);
		byte_word = {24'h00_0000, b};
	endfunction

	function automatic nvba_key_e key_step(input nvba_key_e k, input nvba_byte_t b);
		if (b == `NVBA_KEY_FIRST)
			key_step = NVBA_KEY1;
		else if (b == `NVBA_KEY_SECOND && k == NVBA_KEY1)
			key_step = NVBA_KEY2; // see R10
		else
			key_step = NVBA_IDLE;
	endfunction

	// abort resets share one path
	assign abort_rst = EXT_PIN_RST | WDOG_RST | BROWNOUT_RST;
	assign soft_rst = abort_rst;
	assign bus_ok = HSEL & HTRANS[1] & HREADY;
	assign mem_we = regs_r.go && tmr_r == 32'h0000_0001 && !abort_rst;
	assign key_wr = wr_ph_r && wr_idx_r == `NVBA_IDX_KEY;
	assign ctl_wr = wr_ph_r && wr_idx_r == `NVBA_IDX_CTRL;
	assign go_start = ctl_wr && HWDATA[`NVBA_BIT_GO] && regs_r.permit && !regs_r.go
		&& key_r == NVBA_KEY2;

	// bus phases; read mux sees this cycle's writes
	always_comb
	begin
		wr_ph_nxt = bus_ok & HWRITE;
		wr_idx_nxt = bus_ok ? idx_of(HADDR) : wr_idx_r;
		rdata_nxt = 32'h0000_0000;
		if (bus_ok && !HWRITE)
		begin
			case (idx_of(HADDR))
				`NVBA_IDX_DATA:
					rdata_nxt = byte_word(regs_nxt.data);
				`NVBA_IDX_ADDR:
					rdata_nxt = byte_word(regs_nxt.addr);
				`NVBA_IDX_CTRL:
					rdata_nxt = byte_word({4'h0, regs_nxt.fault, regs_nxt.permit,
						regs_nxt.go, regs_nxt.fetch}); // see R01
				`NVBA_IDX_FLAG:
					rdata_nxt = byte_word({regs_nxt.done, 7'h00});
				default:
					rdata_nxt = 32'h0000_0000; // see R19
			endcase
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			wr_ph_r <= 1'b0;
			wr_idx_r <= 8'h00;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else
		begin
			wr_ph_r <= wr_ph_nxt;
			wr_idx_r <= wr_idx_nxt;
			HRDATA <= rdata_nxt;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// unlock key tracking
	always_comb
	begin
		key_nxt = key_r;
		gap_nxt = gap_r;
		if (key_r != NVBA_IDLE && gap_r != 4'h0)
			gap_nxt = gap_r - 4'h1;
		if (key_r != NVBA_IDLE && gap_r == 4'h0)
			key_nxt = NVBA_IDLE; // see R11
		if (key_wr)
		begin
			gap_nxt = 4'(KEY_GAP); // see R11 see R19
			key_nxt = key_step(key_r, HWDATA[7:0]); // see R10
		end
		if (ctl_wr && HWDATA[`NVBA_BIT_GO])
			key_nxt = NVBA_IDLE; // see R10
		if (soft_rst)
			key_nxt = NVBA_IDLE;
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			key_r <= NVBA_IDLE;
			gap_r <= 4'h0;
		end
		else
		begin
			key_r <= key_nxt;
			gap_r <= gap_nxt;
		end
	end

	// write timer and latched target
	always_comb
	begin
		tmr_nxt = tmr_r;
		prog_addr_nxt = prog_addr_r;
		prog_data_nxt = prog_data_r;
		if (regs_r.go)
			tmr_nxt = tmr_r - 32'h0000_0001; // see R23
		if (go_start)
		begin
			tmr_nxt = 32'(PROG_CYCLES); // see R23
			prog_addr_nxt = regs_r.addr;
			prog_data_nxt = regs_r.data;
		end
		if (soft_rst)
			tmr_nxt = 32'h0000_0000;
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			tmr_r <= 32'h0000_0000;
			prog_addr_r <= 8'h00;
			prog_data_r <= 8'h00;
		end
		else
		begin
			tmr_r <= tmr_nxt;
			prog_addr_r <= prog_addr_nxt;
			prog_data_r <= prog_data_nxt;
		end
	end

	// register file
	always_comb
	begin
		regs_nxt = regs_r;
		if (mem_we)
		begin
			regs_nxt.go = 1'b0; // see R04 see R17
			regs_nxt.done = 1'b1; // see R17
			regs_nxt.fault = 1'b0; // see R02
		end
		if (regs_r.fetch)
		begin
			regs_nxt.data = mem_r[regs_r.addr[6:0]]; // see R06 see R07 see R20
			regs_nxt.fetch = 1'b0; // see R05
		end
		if (wr_ph_r)
		begin
			case (wr_idx_r)
				`NVBA_IDX_DATA:
					regs_nxt.data = HWDATA[7:0]; // see R07 see R22
				`NVBA_IDX_ADDR:
					regs_nxt.addr = HWDATA[7:0];
				`NVBA_IDX_CTRL:
				begin
					regs_nxt.permit = HWDATA[`NVBA_BIT_PERMIT]; // see R03 see R15
					regs_nxt.fault = HWDATA[`NVBA_BIT_FAULT];
					if (HWDATA[`NVBA_BIT_FETCH] && !regs_r.go)
						regs_nxt.fetch = 1'b1; // see R05 see R24
					if (go_start)
						regs_nxt.go = 1'b1; // see R10 see R13 see R14
				end
				`NVBA_IDX_FLAG:
					if (!HWDATA[`NVBA_BIT_DONE])
						regs_nxt.done = 1'b0; // see R18
				default:
					regs_nxt = regs_nxt;
			endcase
		end
		if (mem_we)
			regs_nxt.done = 1'b1; // see R18
		if (soft_rst)
		begin
			regs_nxt.fault = regs_r.go; // see R02
			regs_nxt.go = 1'b0;
			regs_nxt.fetch = 1'b0;
			regs_nxt.permit = `NVBA_RST_PERMIT; // see R03
			regs_nxt.addr = regs_r.addr; // see R22
			regs_nxt.data = regs_r.data;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			regs_r <= '0;
			PROG_DONE <= 1'b0;
		end
		else
		begin
			regs_r <= regs_nxt;
			PROG_DONE <= regs_nxt.done;
		end
	end

	// array write, blocked by an abort
	always_ff @(posedge CLK)
	begin
		if (mem_we)
			mem_r[prog_addr_r[6:0]] <= prog_data_r; // see R21 see R20
	end
endmodule

// ### test/nvba_top_checker.sv
// Purpose: port checks for the byte access block
// Assumes: zero wait bus, count runs from the go write
// Notes: bound to nvba_top below
`timescale 1ns/1ps
module nvba_chk
	import nvba_pkg::*;
#(
	parameter int PROG_CYCLES = 8
)
(
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        EXT_PIN_RST,
	input wire logic        WDOG_RST,
	input wire logic        BROWNOUT_RST,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        PROG_DONE
);
	logic [31:0] ph_a;
	logic        ph_v, ph_w, rd, clr;
	int          since_go;
	assign rd = ph_v && !ph_w;
	assign clr = ph_v && ph_w && ph_a == 32'h0000_0030 && !HWDATA[7];
	always_ff @(posedge CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			{ph_v, ph_w, ph_a} <= '0;
			since_go <= 0;
		end
		else
		begin
			ph_v <= HSEL && HTRANS[1] && HREADY;
			ph_w <= HWRITE;
			ph_a <= HADDR;
			if (ph_v && ph_w && ph_a == 32'h0000_0270 && HWDATA[1])
				since_go <= 0;
			else if (since_go < 999)
				since_go <= since_go + 1;
		end
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	chk_ready_high: assert property (HREADYOUT)
		else $error("ready low");
	chk_resp_okay: assert property (!HRESP)
		else $error("error response");
	chk_rd_idle: assert property (!rd |-> HRDATA == 32'h0000_0000)
		else $error("read data outside data phase");
	chk_ctrl_upper: assert property (rd && ph_a == 32'h0000_0270 |-> HRDATA[31:4] == '0)
		else $error("control upper bits set");
	chk_key_zero: assert property (rd && ph_a == 32'h0000_0274 |-> HRDATA == '0)
		else $error("key port read not zero");
	chk_done_clear: assert property ($fell(PROG_DONE) |-> $past(clr) || $past(clr, 2))
		else $error("done dropped without clear");
	chk_done_time: assert property ($rose(PROG_DONE) |-> since_go inside {[PROG_CYCLES - 1:PROG_CYCLES + 2]})
		else $error("done at wrong time");
	chk_done_soft: assert property ((EXT_PIN_RST || WDOG_RST || BROWNOUT_RST) && PROG_DONE |=> PROG_DONE)
		else $error("done lost on soft reset");
endmodule
bind nvba_top nvba_chk #(.PROG_CYCLES(PROG_CYCLES)) i_nvba_chk (.*);

// ### test/test_nvm_byte_access.sv
// Purpose: self-checking bench for nvba_top
// Assumes: write time shortened to 8 cycles
// Notes: address and data drawn from a fixed seed
`timescale 1ns/1ps
module test_nvm_byte_access;
	localparam logic [31:0] DAT = 32'h0000_0268, ADR = 32'h0000_026c, CTL = 32'h0000_0270;
	localparam logic [31:0] KEY = 32'h0000_0274, FLG = 32'h0000_0030;
	logic        CLK = 0, SYS_RST = 1, EXT_PIN_RST = 0, WDOG_RST = 0, BROWNOUT_RST = 0;
	logic        HSEL = 0, HWRITE = 0, HREADY, HREADYOUT, HRESP, PROG_DONE;
	logic [1:0]  HTRANS = '0;
	logic [2:0]  HSIZE = 3'h2;
	logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, r;
	logic [7:0]  a, d, m;
	logic [31:0] cs [6] = '{32'h55aa_0401, 32'h55aa_0441, 32'haa55_0440, 32'h55aa_6440,
		32'h5555_0440, 32'h55aa_0000};
	int          seed = 32'h34ca, bad_count = 0, n_tests = 0, k;
	assign HREADY = HREADYOUT;
	nvba_top #(.PROG_CYCLES(8)) i_nvba_top (.*);
	initial forever #12.5 CLK = ~CLK;
	task test_done;
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt;
		k = 0;
		do
		begin
			@(posedge CLK);
			k++;
		end
		while (HREADYOUT !== 1'b1 && k < 20);
		if (HREADYOUT !== 1'b1)
		begin
			bad_count++;
			test_done;
		end
	endtask
	task xf(input logic [31:0] ad, input logic w, input logic [7:0] dt);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= ad;
		HWRITE <= w;
		wt;
		HTRANS <= 2'h0;
		HWDATA <= {24'h00_0000, dt};
		wt;
		r = HRDATA;
	endtask
	task prog(input logic [31:0] c);
		d = $random(seed);
		xf(DAT, 1, d);
		xf(CTL, 1, c[11:8]);
		xf(KEY, 1, c[31:24]);
		repeat (c[15:12]) @(posedge CLK);
		xf(KEY, 1, c[23:16]);
		xf(CTL, 1, c[11:8] | 8'h02);
		xf(CTL, 1, c[7:4]);
		for (k = 0; k < 30 && PROG_DONE !== 1'b1; k++)
			@(posedge CLK);
	endtask
	initial
	begin
		repeat (2) @(posedge CLK);
		SYS_RST <= 1'b0;
		a = $random(seed) & 8'h7f;
		xf(CTL, 0, 0);
		chk("ctrl", r, 0);
		xf(KEY, 0, 0);
		chk("key", r, 0);
		xf(32'h0000_0100, 1, 8'hff);
		xf(32'h0000_0100, 0, 0);
		chk("unmapped", r, 0);
		xf(ADR, 1, a);
		for (int i = 0; i < 6; i++)
		begin
			prog(cs[i]);
			chk("done", PROG_DONE, cs[i][0]);
			if (cs[i][0])
				m = d;
			xf(CTL, 0, 0);
			chk("ctrl", r, cs[i][7:4]);
			xf(FLG, 0, 0);
			chk("flag", r, {cs[i][0], 7'h0});
			xf(FLG, 1, 0);
			xf(DAT, 1, ~d);
			xf(CTL, 1, 1);
			xf(DAT, 0, 0);
			chk("data", r, m);
		end
		prog(cs[1]);
		for (int i = 0; i < 3; i++)
		begin
			prog(32'h55aa_0444);
			{EXT_PIN_RST, WDOG_RST, BROWNOUT_RST} <= 3'h1 << i;
			@(posedge CLK);
			{EXT_PIN_RST, WDOG_RST, BROWNOUT_RST} <= 3'h0;
			xf(CTL, 0, 0);
			chk("fault", r, 8'h08);
			xf(ADR, 0, 0);
			chk("addr", r, a);
			xf(DAT, 0, 0);
			chk("data", r, d);
			chk("done", PROG_DONE, 1);
		end
		test_done;
	end
endmodule
